// File: shared/pdd_cfg.svh
// Constants for the pixel DPCM decompressor: masks, match values, offsets, reset values
`ifndef PDD_CFG_SVH
`define PDD_CFG_SVH
// 7-bit scheme: non-predicted offset
`define PDD_NP7_OFS   10'h004
// 7-bit class masks and match values
`define PDD_M7_C1     7'h70
`define PDD_V7_C1     7'h00
`define PDD_M7_C23    7'h78
`define PDD_V7_C2     7'h10
`define PDD_V7_C3     7'h18
`define PDD_M7_C4     7'h60
`define PDD_V7_C4     7'h20
// 7-bit magnitude offsets and raw rounding
`define PDD_OFS7_C2   10'h008
`define PDD_OFS7_C3   10'h011
`define PDD_OFS7_C4   10'h023
`define PDD_RAW7_LO   10'h007
`define PDD_RAW7_HI   10'h008
// 6-bit scheme: non-predicted offset
`define PDD_NP6_OFS   10'h008
// 6-bit class masks and match values
`define PDD_M6_C12    6'h3e
`define PDD_V6_C1     6'h00
`define PDD_V6_C2     6'h02
`define PDD_M6_C3     6'h3c
`define PDD_V6_C3     6'h04
`define PDD_M6_C4     6'h38
`define PDD_V6_C4     6'h08
`define PDD_M6_C5     6'h30
`define PDD_V6_C5     6'h10
// 6-bit magnitude offsets and raw rounding
`define PDD_MAG6_C2   10'h001
`define PDD_OFS6_C3   10'h004
`define PDD_OFS6_C4   10'h00e
`define PDD_OFS6_C5   10'h032
`define PDD_RAW6_LO   10'h00f
`define PDD_RAW6_HI   10'h010
// Clamp limit of the 10-bit pixel range
`define PDD_PIX_MAX   12'sh3ff
// Reset values and depth of the output buffer
`define PDD_CNT_RST   2'h0
`define PDD_PTR_RST   1'h0
`define PDD_BUF_DEPTH 2'h2
`endif

// File: shared/pdd_pkg.sv
// Types shared by the pixel DPCM decompressor
`default_nettype none
package pdd_pkg;
	// Decoded class of a predicted code word
	typedef enum logic [2:0] {
		PDD_CLS_C1  = 3'h0,
		PDD_CLS_C2  = 3'h1,
		PDD_CLS_C3  = 3'h3,
		PDD_CLS_C4  = 3'h2,
		PDD_CLS_C5  = 3'h6,
		PDD_CLS_RAW = 3'h7
	} pdd_class_t;
endpackage : pdd_pkg
`default_nettype wire

// File: design/pdd_decompressor.sv
// Pixel DPCM decompressor: 7-bit and 6-bit codes back to 10-bit pixels, two-entry output buffer
//
// Operation
// - 7-bit non-predicted pixel is eight times the code plus four.
// - 7-bit predicted codes classified by masks 0x70, 0x78, 0x78, 0x60, else raw.
// - 7-bit class one: sign bit 3, magnitude low three bits, no clamp.
// - 7-bit class two: sign bit 2, magnitude twice low bits plus eight.
// - 7-bit class three: sign bit 2, four times low bits plus seventeen, clamped.
// - 7-bit class four: sign bit 4, eight times low bits plus 35, clamped.
// - 7-bit raw: base sixteen times low six bits, plus seven or eight.
// - 6-bit non-predicted pixel is sixteen times the code plus eight.
// - 6-bit predicted codes classified by masks 0x3e, 0x3e, 0x3c, 0x38, 0x30.
// - 6-bit class one outputs the prediction unchanged.
// - 6-bit class two: sign bit 0, magnitude one, no clamp.
// - 6-bit class three: sign bit 1, four times bit zero plus four, clamped.
// - 6-bit class four: sign bit 2, eight times low bits plus fourteen, clamped.
// - 6-bit class five: sign bit 3, sixteen times low bits plus fifty, clamped.
// - 6-bit raw: base thirty-two times low five bits, plus fifteen or sixteen.
// - Line-start pixels use the scaling formula, all others predicted decoding.
`timescale 1ns/1ps
`include "pdd_cfg.svh"
`default_nettype none

module pdd_decompressor (
	input  wire logic       clk_sys_in,
	input  wire logic       arst_n_in,
	input  wire logic       ce_in,
	input  wire logic       mode_6bit_in,
	input  wire logic       in_valid_in,
	input  wire logic [6:0] in_code_in,
	input  wire logic [9:0] in_pred_in,
	input  wire logic       in_first_in,
	output logic            in_ready_out,
	output logic            out_valid_out,
	output logic [9:0]      out_pixel_out,
	input  wire logic       out_ready_in
);

	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------

	// Adds or subtracts a magnitude; clamps only when asked, else wraps to 10 bits
	function automatic logic [9:0] pdd_apply(
		input logic [9:0] pred,
		input logic       neg,
		input logic [9:0] mag,
		input logic       clamp
	);
		logic signed [11:0] sum;
		sum = neg ? $signed({2'h0, pred}) - $signed({2'h0, mag})
		          : $signed({2'h0, pred}) + $signed({2'h0, mag});
		if (clamp && sum < 0)
			return 10'h000;
		else if (clamp && sum > `PDD_PIX_MAX)
			return 10'h3ff;
		else
			return sum[9:0];
	endfunction : pdd_apply

	// Priority classifier of the 7-bit scheme
	function automatic pdd_pkg::pdd_class_t pdd_class7(input logic [6:0] code);
		if ((code & `PDD_M7_C1) == `PDD_V7_C1)
			return pdd_pkg::PDD_CLS_C1;
		else if ((code & `PDD_M7_C23) == `PDD_V7_C2)
			return pdd_pkg::PDD_CLS_C2;
		else if ((code & `PDD_M7_C23) == `PDD_V7_C3)
			return pdd_pkg::PDD_CLS_C3;
		else if ((code & `PDD_M7_C4) == `PDD_V7_C4)
			return pdd_pkg::PDD_CLS_C4;
		else
			return pdd_pkg::PDD_CLS_RAW;
	endfunction : pdd_class7

	// Priority classifier of the 6-bit scheme
	function automatic pdd_pkg::pdd_class_t pdd_class6(input logic [5:0] code);
		if ((code & `PDD_M6_C12) == `PDD_V6_C1)
			return pdd_pkg::PDD_CLS_C1;
		else if ((code & `PDD_M6_C12) == `PDD_V6_C2)
			return pdd_pkg::PDD_CLS_C2;
		else if ((code & `PDD_M6_C3) == `PDD_V6_C3)
			return pdd_pkg::PDD_CLS_C3;
		else if ((code & `PDD_M6_C4) == `PDD_V6_C4)
			return pdd_pkg::PDD_CLS_C4;
		else if ((code & `PDD_M6_C5) == `PDD_V6_C5)
			return pdd_pkg::PDD_CLS_C5;
		else
			return pdd_pkg::PDD_CLS_RAW;
	endfunction : pdd_class6

	// Full decode of one 7-bit sample
	function automatic logic [9:0] pdd_dec7(
		input logic [6:0] code,
		input logic [9:0] pred,
		input logic       first
	);
		logic [9:0] base;
		base = {code[5:0], 4'h0};
		if (first)
			return {code, 3'h0} + `PDD_NP7_OFS;
		case (pdd_class7(code))
			pdd_pkg::PDD_CLS_C1:
				return pdd_apply(pred, code[3], {7'h0, code[2:0]}, 1'b0);
			pdd_pkg::PDD_CLS_C2:
				return pdd_apply(pred, code[2], {7'h0, code[1:0], 1'b0} + `PDD_OFS7_C2,
				                 1'b0);
			pdd_pkg::PDD_CLS_C3:
				return pdd_apply(pred, code[2], {6'h0, code[1:0], 2'h0} + `PDD_OFS7_C3,
				                 1'b1);
			pdd_pkg::PDD_CLS_C4:
				return pdd_apply(pred, code[4], {3'h0, code[3:0], 3'h0} + `PDD_OFS7_C4,
				                 1'b1);
			default:
				return (base > pred) ? base + `PDD_RAW7_LO : base + `PDD_RAW7_HI;
		endcase
	endfunction : pdd_dec7

	// Full decode of one 6-bit sample
	function automatic logic [9:0] pdd_dec6(
		input logic [5:0] code,
		input logic [9:0] pred,
		input logic       first
	);
		logic [9:0] base;
		base = {code[4:0], 5'h00};
		if (first)
			return {code, 4'h0} + `PDD_NP6_OFS;
		case (pdd_class6(code))
			pdd_pkg::PDD_CLS_C1:
				return pred;
			pdd_pkg::PDD_CLS_C2:
				return pdd_apply(pred, code[0], `PDD_MAG6_C2, 1'b0);
			pdd_pkg::PDD_CLS_C3:
				return pdd_apply(pred, code[1], {7'h0, code[0], 2'h0} + `PDD_OFS6_C3,
				                 1'b1);
			pdd_pkg::PDD_CLS_C4:
				return pdd_apply(pred, code[2], {5'h0, code[1:0], 3'h0} + `PDD_OFS6_C4,
				                 1'b1);
			pdd_pkg::PDD_CLS_C5:
				return pdd_apply(pred, code[3], {3'h0, code[2:0], 4'h0} + `PDD_OFS6_C5,
				                 1'b1);
			default:
				return (base > pred) ? base + `PDD_RAW6_LO : base + `PDD_RAW6_HI;
		endcase
	endfunction : pdd_dec6

	// ----------------------------------------------------------------
	// Decode and handshake
	// ----------------------------------------------------------------

	logic [9:0] pix_next;
	logic       push;
	logic       pop;
	logic [1:0] cnt_reg;
	logic       wr_ptr_reg;
	logic       rd_ptr_reg;
	logic [9:0] buf_mem [0:1];

	// Decode is combinational so a sample lands in the buffer on the edge it is taken
	always_comb
	begin
		if (mode_6bit_in)
			pix_next = pdd_dec6(in_code_in[5:0], in_pred_in, in_first_in);
		else
			pix_next = pdd_dec7(in_code_in, in_pred_in, in_first_in);
	end

	// Ready only depends on buffer fill, so upstream never sees a loop through out_ready_in
	assign in_ready_out  = (cnt_reg != `PDD_BUF_DEPTH);
	assign out_valid_out = (cnt_reg != `PDD_CNT_RST);
	assign out_pixel_out = buf_mem[rd_ptr_reg];
	assign push          = ce_in && in_valid_in && in_ready_out;
	assign pop           = ce_in && out_valid_out && out_ready_in;

	// ----------------------------------------------------------------
	// Two-entry output buffer
	// ----------------------------------------------------------------

	// Fill count; a stalled receiver fills both entries and then drops ready
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			cnt_reg <= `PDD_CNT_RST;
		else if (push && !pop)
			cnt_reg <= cnt_reg + 2'h1;
		else if (pop && !push)
			cnt_reg <= cnt_reg - 2'h1;
	end

	// Write and read pointers
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wr_ptr_reg <= `PDD_PTR_RST;
			rd_ptr_reg <= `PDD_PTR_RST;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= ~wr_ptr_reg;
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
		end
	end

	// Storage; no reset needed since valid gates every read
	always_ff @(posedge clk_sys_in)
	begin
		if (push)
			buf_mem[wr_ptr_reg] <= pix_next;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	logic direct;
	assign direct = push && (cnt_reg == `PDD_CNT_RST);

	// A full buffer that is not drained must keep refusing and keep its head word
	buf_full_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(!in_ready_out && !pop) |=> !in_ready_out && $stable(out_pixel_out))
		else $error("Full buffer lost or changed a word");

	fixed_lat_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		direct |=> out_valid_out)
		else $error("Accepted sample not presented after one cycle");

	np_seven_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && !mode_6bit_in && in_first_in)
		|=> out_pixel_out == {$past(in_code_in), 3'h0} + 10'h004)
		else $error("Wrong 7-bit line-start pixel");

	np_six_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && mode_6bit_in && in_first_in)
		|=> out_pixel_out == {$past(in_code_in[5:0]), 4'h0} + 10'h008)
		else $error("Wrong 6-bit line-start pixel");

	pass_six_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && mode_6bit_in && !in_first_in && in_code_in[5:1] == 5'h00)
		|=> out_pixel_out == $past(in_pred_in))
		else $error("6-bit class one changed prediction");

	dec_six_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && mode_6bit_in && !in_first_in && in_code_in[5:0] == 6'h03)
		|=> out_pixel_out == $past(in_pred_in) - 10'h001)
		else $error("6-bit class two negative step wrong");

	raw_seven_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && !mode_6bit_in && !in_first_in && in_code_in[6])
		|=> out_pixel_out[3:0] == 4'h7 || out_pixel_out[3:0] == 4'h8)
		else $error("7-bit raw rounding wrong");

	clamp_low_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && !mode_6bit_in && !in_first_in && in_code_in[6:5] == 2'h1
		 && in_code_in[4] && in_pred_in < 10'h023)
		|=> out_pixel_out == 10'h000)
		else $error("7-bit class four not clamped to zero");

	hold_out_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(out_valid_out && !out_ready_in) |=> out_valid_out && $stable(out_pixel_out))
		else $error("Output changed while stalled");

	// Exact results per class on a direct hand-over, written from the class formulas
	cls_one_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && !mode_6bit_in && !in_first_in && in_code_in[6:4] == 3'h0)
		|=> out_pixel_out == ($past(in_code_in[3])
			? $past(in_pred_in) - {7'h0, $past(in_code_in[2:0])}
			: $past(in_pred_in) + {7'h0, $past(in_code_in[2:0])}))
		else $error("7-bit class one step wrong");

	cls_two_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && !mode_6bit_in && !in_first_in && in_code_in[6:2] == 5'h04)
		|=> out_pixel_out == $past(in_pred_in) + {7'h0, $past(in_code_in[1:0]), 1'b0}
			+ 10'h008)
		else $error("7-bit class two positive step wrong");

	cls_three_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && !mode_6bit_in && !in_first_in && in_code_in[6:2] == 5'h07)
		|=> out_pixel_out == (($past(in_pred_in)
			< {6'h0, $past(in_code_in[1:0]), 2'h0} + 10'h011) ? 10'h000
			: $past(in_pred_in) - {6'h0, $past(in_code_in[1:0]), 2'h0} - 10'h011))
		else $error("7-bit class three negative step wrong");

	clamp_high_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && !mode_6bit_in && !in_first_in && in_code_in[6:4] == 3'h2
		 && in_pred_in == 10'h3ff)
		|=> out_pixel_out == 10'h3ff)
		else $error("7-bit class four not clamped to full scale");

	six_three_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && mode_6bit_in && !in_first_in && in_code_in[5:1] == 5'h02)
		|=> out_pixel_out == (($past(in_pred_in)
			> 10'h3fb - {7'h0, $past(in_code_in[0]), 2'h0}) ? 10'h3ff
			: $past(in_pred_in) + {7'h0, $past(in_code_in[0]), 2'h0} + 10'h004))
		else $error("6-bit class three positive step wrong");

	six_four_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && mode_6bit_in && !in_first_in && in_code_in[5:2] == 4'h3)
		|=> out_pixel_out == (($past(in_pred_in)
			< {5'h0, $past(in_code_in[1:0]), 3'h0} + 10'h00e) ? 10'h000
			: $past(in_pred_in) - {5'h0, $past(in_code_in[1:0]), 3'h0} - 10'h00e))
		else $error("6-bit class four negative step wrong");

	six_five_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && mode_6bit_in && !in_first_in && in_code_in[5:3] == 3'h2)
		|=> out_pixel_out == (($past(in_pred_in)
			> 10'h3cd - {3'h0, $past(in_code_in[2:0]), 4'h0}) ? 10'h3ff
			: $past(in_pred_in) + {3'h0, $past(in_code_in[2:0]), 4'h0} + 10'h032))
		else $error("6-bit class five positive step wrong");

	raw_six_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		(direct && mode_6bit_in && !in_first_in && in_code_in[5])
		|=> out_pixel_out == (({$past(in_code_in[4:0]), 5'h00} > $past(in_pred_in))
			? {$past(in_code_in[4:0]), 5'h0f} : {$past(in_code_in[4:0]), 5'h10}))
		else $error("6-bit raw value wrong");

	// Storage is left out here: it holds no defined word before the first write
	ce_hold_a: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
		!ce_in |=> $stable(cnt_reg) && $stable(wr_ptr_reg) && $stable(rd_ptr_reg))
		else $error("Buffer state moved while clock enable low");

endmodule : pdd_decompressor
`default_nettype wire

// File: bench/pdd_sink.sv
// Downstream pipeline model: takes pixels with random and forced stalls
`timescale 1ns/1ps
`default_nettype none

module pdd_sink (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	input  wire logic stall_in,
	output var  logic ready_out
);
	// Ready drops at random one cycle in four, so the buffer is exercised
	always @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ready_out <= 1'b0;
		else
			ready_out <= !stall_in && (($urandom % 4) != 0);
	end
endmodule : pdd_sink
`default_nettype wire

// File: bench/pixel_dpcm_decompressor_bench.sv
// Self-checking bench for the pixel DPCM decompressor
`timescale 1ns/1ps
`default_nettype none

module pixel_dpcm_decompressor_bench;
	logic       clk_sys_in   = 1'b0;
	logic       arst_n_in    = 1'b0;
	logic       ce_in        = 1'b0;
	logic       mode_6bit_in = 1'b0;
	logic       in_valid_in  = 1'b0;
	logic [6:0] in_code_in   = 7'h00;
	logic [9:0] in_pred_in   = 10'h000;
	logic       in_first_in  = 1'b0;
	logic       stall        = 1'b0;
	logic       in_ready_out;
	logic       out_valid_out;
	logic [9:0] out_pixel_out;
	logic       out_ready_in;
	logic [9:0] exp_q[$];
	int         error_cnt    = 0;
	int         n_checks     = 0;
	logic       hung         = 1'b0;

	pdd_decompressor i_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
		.mode_6bit_in(mode_6bit_in), .in_valid_in(in_valid_in), .in_code_in(in_code_in),
		.in_pred_in(in_pred_in), .in_first_in(in_first_in), .in_ready_out(in_ready_out),
		.out_valid_out(out_valid_out), .out_pixel_out(out_pixel_out),
		.out_ready_in(out_ready_in));
	pdd_sink i_sink (.clk_in(clk_sys_in), .arst_n_in(arst_n_in), .stall_in(stall),
		.ready_out(out_ready_in));

	initial forever #25 clk_sys_in = ~clk_sys_in;

	// -------------------------------------------------------
	// Reference decoder and reporting
	// -------------------------------------------------------
	function automatic logic [9:0] ref_pix(input logic m6, input logic [6:0] c,
		input logic [9:0] p, input logic f);
		int   v;
		int   r;
		logic s;
		logic cl;
		cl = 1'b1;
		s = 1'b0;
		if (f) return m6 ? {c[5:0], 4'h8} : {c, 3'h4};
		if (m6)
		begin
			if (c[5:1] == 5'h00) return p;
			else if (c[5:1] == 5'h01) begin s = c[0]; v = 1; cl = 1'b0; end
			else if (c[5:2] == 4'h1) begin s = c[1]; v = 4 * c[0] + 4; end
			else if (c[5:3] == 3'h1) begin s = c[2]; v = 8 * c[1:0] + 14; end
			else if (c[5:4] == 2'h1) begin s = c[3]; v = 16 * c[2:0] + 50; end
			else begin v = 32 * c[4:0]; return (v > p) ? 10'(v + 15) : 10'(v + 16); end
		end
		else
		begin
			if (c[6:4] == 3'h0) begin s = c[3]; v = c[2:0]; cl = 1'b0; end
			else if (c[6:3] == 4'h2) begin s = c[2]; v = 2 * c[1:0] + 8; cl = 1'b0; end
			else if (c[6:3] == 4'h3) begin s = c[2]; v = 4 * c[1:0] + 17; end
			else if (c[6:5] == 2'h1) begin s = c[4]; v = 8 * c[3:0] + 35; end
			else begin v = 16 * c[5:0]; return (v > p) ? 10'(v + 7) : 10'(v + 8); end
		end
		r = s ? p - v : p + v;
		// Small classes wrap, larger ones saturate at the pixel range
		if (!cl) return 10'(r);
		return (r < 0) ? 10'h000 : ((r > 1023) ? 10'h3ff : 10'(r));
	endfunction : ref_pix

	task automatic mismatch(input string m);
		error_cnt++;
		$display("MISMATCH at %0t: %s", $time, m);
	endtask : mismatch

	task automatic print_verdict;
		$display("checks %0d, errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// -------------------------------------------------------
	// Expectation notes and output watcher
	// -------------------------------------------------------
	// Note each accepted sample with the mode that was in force
	always @(posedge clk_sys_in)
	begin
		if (arst_n_in && ce_in && in_valid_in && in_ready_out)
			exp_q.push_back(ref_pix(mode_6bit_in, in_code_in, in_pred_in, in_first_in));
	end

	// Watch at the falling edge, where every output has settled
	always @(negedge clk_sys_in)
	begin
		if (arst_n_in)
		begin
			n_checks++;
			if (in_ready_out !== (exp_q.size() < 2) || out_valid_out !== (exp_q.size() != 0))
				mismatch("buffer flags disagree with words held");
			if (ce_in && out_valid_out && out_ready_in && exp_q.size() != 0)
			begin
				n_checks++;
				if (out_pixel_out !== exp_q[0]) mismatch("pixel value wrong");
				void'(exp_q.pop_front());
			end
		end
	end

	// -------------------------------------------------------
	// Stimulus: lines of random samples, modes alternate
	// -------------------------------------------------------
	initial
	begin
		void'($urandom(19));
		repeat (3) @(posedge clk_sys_in);
		arst_n_in <= 1'b1;
		for (int ln = 0; ln < 24; ln++)
		begin
			// Let the pending sample land before the mode changes
			@(posedge clk_sys_in);
			ce_in <= 1'b1;
			stall <= 1'b0;
			for (int w = 0; in_valid_in && !(ce_in && in_ready_out); w++)
			begin
				if (w == 60) begin mismatch("input never accepted"); hung = 1'b1; break; end
				@(posedge clk_sys_in);
			end
			// A hang skips the remaining lines and goes on to the closing report
			if (hung) break;
			in_valid_in <= 1'b0;
			mode_6bit_in <= ln[0];
			stall <= (ln % 6 == 5);
			for (int k = 0; k < 40; k++)
			begin
				@(posedge clk_sys_in);
				// A refused sample is held unchanged until taken
				if (!in_valid_in || (ce_in && in_ready_out))
				begin
					in_valid_in <= ($urandom % 8) != 0;
					in_code_in <= 7'($urandom);
					in_pred_in <= ($urandom % 4 == 0) ? 10'h000 :
						(($urandom % 3 == 0) ? 10'h3ff : 10'($urandom));
					in_first_in <= (k == 0) || ($urandom % 16 == 0);
				end
				ce_in <= ($urandom % 8) != 0;
			end
		end
		@(posedge clk_sys_in);
		in_valid_in <= 1'b0;
		ce_in <= 1'b1;
		stall <= 1'b0;
		for (int w = 0; exp_q.size() != 0; w++)
		begin
			if (w == 200) begin mismatch("buffer never drained"); break; end
			@(posedge clk_sys_in);
		end
		print_verdict();
	end
endmodule : pixel_dpcm_decompressor_bench
`default_nettype wire
